// ==== hdl/trap_env_csr.sv ====
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Trap entry loads trap value; otherwise software only.
// - No informative values means trap value reads zero.
// - Address-type exceptions record the faulting virtual address.
// - Translated accesses record virtual address, even access faults.
// - Misaligned access faults record the faulting portion address.
// - Fetch faults record portion address, not instruction start.
// - Illegal instruction bits: shortest of instr, length, width.
// - Instruction bits right-aligned, upper bits zeroed.
// - Instruction bits must be fully fetched before trap.
// - All other traps write zero into trap value.
// - Writable trap value holds zero and valid addresses.
// - Instruction capture needs values below two to N.
// - Read-only configuration pointer; zero means none.
// - Configuration pointer low bits always read zero.
// - Set fence bit widens device fences to memory.
// - Ordered atomics to device regions also order memory.
// - Fence bit may be hardwired zero without translation.
// - Memory-type enable bit, zero when unimplemented.
// - Hypervisor memory-type enable forced zero when ours zero.
// - Future fields reserved at their fixed bit positions.
// - Narrow machines split environment register in two.
// - No user mode means no environment registers.
module trap_env_csr
   import trap_env_pkg::*;
#(
   parameter int          XLEN          = 64,
   parameter int          IMAX          = 32,
   parameter bit          TVAL_NONZERO  = 1'b1,
   parameter bit          INSTR_CAPTURE = 1'b1,
   parameter bit          HAS_U         = 1'b1,
   parameter bit          HAS_S         = 1'b1,
   parameter bit          XLATE_BARE    = 1'b0,
   parameter bit          HAS_MEMTYPE   = 1'b1,
   parameter bit          FUTURE_FIELDS = 1'b0,
   parameter bit          HAS_SEC_CFG   = 1'b1,
   parameter logic [63:0] CONFIG_PTR    = 64'h0000_0000_0000_0000
)
(
   // Clock and reset.
   input  wire logic            clock,
   input  wire logic            rst_n,
   // Register-access port from the core.
   input  wire logic            csr_valid,
   input  wire logic            csr_write,
   input  wire logic [11:0]     csr_addr,
   input  wire logic [XLEN-1:0] csr_wdata,
   output logic      [XLEN-1:0] csr_rdata,
   output logic                 csr_rvalid,
   output logic                 csr_error,
   // Trap entry from the core's trap logic.
   input  wire logic            trap_valid,
   input  wire logic            trap_interrupt,
   input  wire logic [5:0]      trap_cause,
   input  wire logic [XLEN-1:0] trap_vaddr,
   input  wire logic [IMAX-1:0] trap_instr_bits,
   input  wire logic [3:0]      trap_instr_parcels,
   input  wire logic            trap_instr_valid,
   // Fence and atomic ordering from the execute stage.
   input  wire logic            priv_below_m,
   input  wire logic            pred_dev_input,
   input  wire logic            pred_dev_output,
   input  wire logic            succ_dev_input,
   input  wire logic            succ_dev_output,
   input  wire logic            amo_io_ordered,
   output logic                 fence_pred_mem_read,
   output logic                 fence_pred_mem_write,
   output logic                 fence_succ_mem_read,
   output logic                 fence_succ_mem_write,
   output logic                 amo_order_memory,
   // Configuration levels to the rest of the hart.
   output logic                 fence_io_implies_memory,
   output logic                 page_memtype_enable,
   output logic                 hyp_memtype_allowed,
   output logic                 supervisor_timecmp_enable,
   output logic                 cache_block_zero_enable,
   output logic                 cache_block_clean_flush_enable,
   output logic [1:0]           cache_block_inval_enable,
   output logic [XLEN-1:0]      trap_value
);

   // Smaller of the machine width and the longest instruction.
   localparam int CAP_N = (XLEN < IMAX) ? XLEN : IMAX;
   // Pointer alignment: low log2(XLEN/8) bits are forced to zero.
   localparam int PTR_ZERO_BITS = $clog2(XLEN / 8);

   // Fence widening is only kept when translation can be on.
   localparam bit FENCE_IO_OK = HAS_S && !XLATE_BARE;
   localparam bit MEMTYPE_OK  = HAS_S && HAS_MEMTYPE;

   // Bits of the 64-bit environment view that software may change.
   localparam logic [63:0] ENV_WMASK =
        (64'(FENCE_IO_OK) << FENCE_IO_BIT)
      | (64'(MEMTYPE_OK) << MEMTYPE_BIT)
      | (64'(FUTURE_FIELDS) << TIMECMP_BIT)
      | (64'(FUTURE_FIELDS) << ZERO_EN_BIT)
      | (64'(FUTURE_FIELDS) << CLEAN_FLUSH_BIT)
      | (64'(FUTURE_FIELDS) << INVAL_LO)
      | (64'(FUTURE_FIELDS) << INVAL_HI);

   // Pointer value with its alignment bits cleared.
   localparam logic [XLEN-1:0] PTR_VALUE =
      XLEN'(CONFIG_PTR) & ~XLEN'((64'h1 << PTR_ZERO_BITS) - 64'h1);

   // Stored state.
   logic [XLEN-1:0] tval_q;        // Trap value register.
   logic [XLEN-1:0] tval_d;        // Its next value.
   logic [63:0]     env_q;         // Environment view, always 64 bits.
   logic [63:0]     env_d;         // Its next value.
   logic [XLEN-1:0] rdata_d;       // Read data for the next cycle.
   logic            err_d;         // Access refused.
   logic            sw_write;      // Accepted software write strobe.

   // True for exceptions whose trap value is a faulting address.
   function automatic logic is_addr_cause(input logic [5:0] code);
      case (code)
         EXC_INSTR_MISALIGN, EXC_INSTR_ACCESS, EXC_BREAKPOINT,
         EXC_LOAD_MISALIGN, EXC_LOAD_ACCESS, EXC_STORE_MISALIGN,
         EXC_STORE_ACCESS, EXC_INSTR_PAGE, EXC_LOAD_PAGE,
         EXC_STORE_PAGE:
            is_addr_cause = 1'b1;
         default:
            is_addr_cause = 1'b0;
      endcase
   endfunction

   // Keeps the shortest of the instruction, IMAX and XLEN bits.
   function automatic logic [XLEN-1:0] instr_value(
      input logic [IMAX-1:0] bits,
      input logic [3:0]      parcels
   );
      int keep;
      keep = int'(parcels) * PARCEL_BITS;
      if (keep > CAP_N)
      begin
         keep = CAP_N;
      end
      instr_value = '0;
      for (int i = 0; i < CAP_N; i++)
      begin
         // Bits at or above the kept length stay zero.
         if (i < keep)
         begin
            instr_value[i] = bits[i];
         end
      end
   endfunction

   // A write lands only on a register that exists and is writable.
   assign sw_write = csr_valid && csr_write && !err_d;

   // Register read decode and refusal of absent or read-only entries.
   always_comb
   begin
      rdata_d = '0;
      err_d   = 1'b0;
      case (csr_addr)
         CSR_TRAP_VALUE:
         begin
            rdata_d = tval_q;
         end
         CSR_CONFIG_PTR:
         begin
            rdata_d = PTR_VALUE;
            err_d   = csr_write;
         end
         CSR_ENV_CONFIG:
         begin
            rdata_d = env_q[XLEN-1:0];
            err_d   = !HAS_U;
         end
         CSR_ENV_CONFIG_HIGH:
         begin
            // The upper half only exists as its own register at 32 bits.
            rdata_d = XLEN'(env_q[63:HALF_W]);
            err_d   = !HAS_U || (XLEN != 32);
         end
         CSR_SEC_CONFIG:
         begin
            // Its fields are not defined yet, so it reads zero.
            err_d = !HAS_SEC_CFG;
         end
         CSR_SEC_CONFIG_HIGH:
         begin
            err_d = !HAS_SEC_CFG || (XLEN != 32);
         end
         default:
         begin
            err_d = 1'b1;
         end
      endcase
   end

   // Next trap value. Trap entry wins over a software write that
   // lands in the same cycle, since the handler must see the cause.
   always_comb
   begin
      tval_d = tval_q;
      if (!TVAL_NONZERO)
      begin
         tval_d = '0;
      end
      else if (trap_valid)
      begin
         // Interrupts and undefined causes record zero.
         tval_d = '0;
         if (!trap_interrupt && is_addr_cause(trap_cause))
         begin
            // The core hands over the virtual address of the faulting
            // portion, which covers translated and misaligned cases.
            tval_d = trap_vaddr;
         end
         else if (!trap_interrupt && trap_cause == EXC_ILLEGAL
                  && INSTR_CAPTURE && trap_instr_valid)
         begin
            // Without fully fetched bits the value falls back to zero.
            tval_d = instr_value(trap_instr_bits,
                                 trap_instr_parcels);
         end
      end
      else if (sw_write && csr_addr == CSR_TRAP_VALUE)
      begin
         // Every value is held, so all legal addresses fit.
         tval_d = csr_wdata;
      end
   end

   // Trap value register.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         tval_q <= XLEN'(TVAL_RESET);
      end
      else
      begin
         tval_q <= tval_d;
      end
   end

   // Next environment view; unwritable bits never leave zero.
   always_comb
   begin
      env_d = env_q;
      if (sw_write && csr_addr == CSR_ENV_CONFIG)
      begin
         if (XLEN == 32)
         begin
            env_d[HALF_W-1:0] = csr_wdata[HALF_W-1:0];
         end
         else
         begin
            env_d = 64'(csr_wdata);
         end
      end
      else if (sw_write && csr_addr == CSR_ENV_CONFIG_HIGH)
      begin
         env_d[63:HALF_W] = csr_wdata[HALF_W-1:0];
      end
      env_d = env_d & ENV_WMASK;
   end

   // Environment configuration register.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         env_q <= ENV_RESET;
      end
      else
      begin
         env_q <= env_d;
      end
   end

   // Registered answer, one cycle after the request.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         csr_rdata  <= '0;
         csr_rvalid <= 1'b0;
         csr_error  <= 1'b0;
      end
      else
      begin
         csr_rdata  <= csr_valid ? rdata_d : '0;
         csr_rvalid <= csr_valid;
         csr_error  <= csr_valid && err_d;
      end
   end

   // Field levels to the rest of the hart.
   assign trap_value                     = tval_q;
   assign fence_io_implies_memory        = env_q[FENCE_IO_BIT];
   assign page_memtype_enable            = env_q[MEMTYPE_BIT];
   assign hyp_memtype_allowed            = env_q[MEMTYPE_BIT];
   assign supervisor_timecmp_enable      = env_q[TIMECMP_BIT];
   assign cache_block_zero_enable        = env_q[ZERO_EN_BIT];
   assign cache_block_clean_flush_enable = env_q[CLEAN_FLUSH_BIT];
   assign cache_block_inval_enable       = env_q[INVAL_HI:INVAL_LO];

   // Fence and atomic widening below machine mode. Machine mode is
   // never affected, so its own fences keep their exact sets.
   assign fence_pred_mem_read  = priv_below_m && env_q[FENCE_IO_BIT]
                                 && pred_dev_input;
   assign fence_pred_mem_write = priv_below_m && env_q[FENCE_IO_BIT]
                                 && pred_dev_output;
   assign fence_succ_mem_read  = priv_below_m && env_q[FENCE_IO_BIT]
                                 && succ_dev_input;
   assign fence_succ_mem_write = priv_below_m && env_q[FENCE_IO_BIT]
                                 && succ_dev_output;
   assign amo_order_memory     = priv_below_m && env_q[FENCE_IO_BIT]
                                 && amo_io_ordered;

   // Checks on the stored state and the answers.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   intr_zero_a: assert property (
      trap_valid && trap_interrupt |=> tval_q == '0)
      else $error("interrupt entry left nonzero trap value");

   fault_addr_a: assert property (
      TVAL_NONZERO && trap_valid && !trap_interrupt
      && is_addr_cause(trap_cause) |=> tval_q == $past(trap_vaddr))
      else $error("address fault did not record address");

   instr_upper_a: assert property (
      trap_valid && !trap_interrupt && trap_cause == EXC_ILLEGAL
      |=> (tval_q >> CAP_N) == '0)
      else $error("instruction value has upper bits set");

   tval_hold_a: assert property (
      !trap_valid && !(csr_valid && csr_write
      && csr_addr == CSR_TRAP_VALUE) |=> $stable(tval_q))
      else $error("trap value changed without cause");

   tval_zero_a: assert property (
      !TVAL_NONZERO |-> tval_q == '0)
      else $error("read-only zero trap value is nonzero");

   ptr_align_a: assert property (
      csr_valid && csr_addr == CSR_CONFIG_PTR
      |=> csr_rvalid && (csr_rdata & XLEN'((64'h1 << PTR_ZERO_BITS)
      - 64'h1)) == '0)
      else $error("configuration pointer misaligned");

   env_high_a: assert property (
      csr_valid && csr_addr == CSR_ENV_CONFIG_HIGH && XLEN != 32
      |=> csr_error)
      else $error("upper environment register answered at 64 bits");

   no_user_a: assert property (
      csr_valid && csr_addr == CSR_ENV_CONFIG && !HAS_U |=> csr_error)
      else $error("environment register present without user mode");

   env_reserved_a: assert property (
      (env_q & ~ENV_WMASK) == 64'h0)
      else $error("reserved environment bits set");

   hyp_memtype_a: assert property (
      !page_memtype_enable |-> !hyp_memtype_allowed)
      else $error("hypervisor memory types allowed while disabled");

   fence_widen_a: assert property (
      !priv_below_m |-> !(fence_pred_mem_read || fence_pred_mem_write
      || fence_succ_mem_read || fence_succ_mem_write))
      else $error("fence widened in machine mode");

   illegal_trap_c: cover property (
      trap_valid && trap_cause == EXC_ILLEGAL && trap_instr_valid);
   env_write_c: cover property (
      csr_valid && csr_write && csr_addr == CSR_ENV_CONFIG ##1
      fence_io_implies_memory);
   trap_over_write_c: cover property (
      trap_valid && csr_valid && csr_write
      && csr_addr == CSR_TRAP_VALUE);

endmodule

`default_nettype wire

// ==== hdl/trap_env_pkg.sv ====
package trap_env_pkg;

   // Register numbers on the core's register-access port.
   localparam logic [11:0] CSR_TRAP_VALUE      = 12'h343;
   localparam logic [11:0] CSR_CONFIG_PTR      = 12'hF15;
   localparam logic [11:0] CSR_ENV_CONFIG      = 12'h30A;
   localparam logic [11:0] CSR_ENV_CONFIG_HIGH = 12'h31A;
   localparam logic [11:0] CSR_SEC_CONFIG      = 12'h747;
   localparam logic [11:0] CSR_SEC_CONFIG_HIGH = 12'h757;

   // Field positions inside the 64-bit environment configuration view.
   localparam int FENCE_IO_BIT    = 0;
   localparam int INVAL_LO        = 4;
   localparam int INVAL_HI        = 5;
   localparam int CLEAN_FLUSH_BIT = 6;
   localparam int ZERO_EN_BIT     = 7;
   localparam int MEMTYPE_BIT     = 62;
   localparam int TIMECMP_BIT     = 63;
   localparam int HALF_W          = 32;

   // Reset values.
   localparam logic [63:0] ENV_RESET  = 64'h0000_0000_0000_0000;
   localparam logic [63:0] TVAL_RESET = 64'h0000_0000_0000_0000;

   // Synchronous exception codes that matter to the trap value.
   localparam logic [5:0] EXC_INSTR_MISALIGN = 6'h00;
   localparam logic [5:0] EXC_INSTR_ACCESS   = 6'h01;
   localparam logic [5:0] EXC_ILLEGAL        = 6'h02;
   localparam logic [5:0] EXC_BREAKPOINT     = 6'h03;
   localparam logic [5:0] EXC_LOAD_MISALIGN  = 6'h04;
   localparam logic [5:0] EXC_LOAD_ACCESS    = 6'h05;
   localparam logic [5:0] EXC_STORE_MISALIGN = 6'h06;
   localparam logic [5:0] EXC_STORE_ACCESS   = 6'h07;
   localparam logic [5:0] EXC_INSTR_PAGE     = 6'h0C;
   localparam logic [5:0] EXC_LOAD_PAGE      = 6'h0D;
   localparam logic [5:0] EXC_STORE_PAGE     = 6'h0F;

   // Width of one instruction parcel in bits.
   localparam int PARCEL_BITS = 16;

endpackage

// ==== dv/core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the core: it makes register accesses and trap entries.
// Everything changes at the falling edge, away from the sampling edge.
module core_model
   import trap_env_pkg::*;
(
   // Clock.
   input  wire logic        clock,
   // Register-access port.
   output logic             csr_valid,
   output logic             csr_write,
   output logic [11:0]      csr_addr,
   output logic [63:0]      csr_wdata,
   input  wire logic [63:0] csr_rdata,
   input  wire logic        csr_rvalid,
   input  wire logic        csr_error,
   // Trap entry port.
   output logic             trap_valid,
   output logic             trap_interrupt,
   output logic [5:0]       trap_cause,
   output logic [63:0]      trap_vaddr,
   output logic [31:0]      trap_instr_bits,
   output logic [3:0]       trap_instr_parcels,
   output logic             trap_instr_valid
);

   // Quiet values at time zero.
   initial
   begin
      csr_valid = 1'b0;
      csr_write = 1'b0;
      csr_addr = 12'h000;
      csr_wdata = 64'h0;
      trap_valid = 1'b0;
      trap_interrupt = 1'b0;
      trap_cause = 6'h00;
      trap_vaddr = 64'h0;
      trap_instr_bits = 32'h0;
      trap_instr_parcels = 4'h0;
      trap_instr_valid = 1'b0;
   end

   // One access; the answer stands in the cycle after the take.
   // Released lines show inverted data so stale values never match.
   task automatic access(input logic wr, input logic [11:0] adr,
      input logic [63:0] wd, output logic [63:0] rd, output logic ok,
      output logic err);
      @(negedge clock);
      csr_valid = 1'b1;
      csr_write = wr;
      csr_addr = adr;
      csr_wdata = wd;
      @(negedge clock);
      rd = csr_rdata;
      ok = csr_rvalid;
      err = csr_error;
      csr_valid = 1'b0;
      csr_write = 1'b0;
      csr_addr = ~csr_addr;
      csr_wdata = ~csr_wdata;
   endtask

   // One trap entry; sw adds a colliding software write of ~va.
   task automatic trap(input logic intr, input logic [5:0] cause,
      input logic [63:0] va, input logic [31:0] bits, input logic [3:0] np,
      input logic iv, input logic sw);
      @(negedge clock);
      trap_valid = 1'b1;
      trap_interrupt = intr;
      trap_cause = cause;
      trap_vaddr = va;
      trap_instr_bits = bits;
      trap_instr_parcels = np;
      trap_instr_valid = iv;
      csr_valid = sw;
      csr_write = sw;
      csr_addr = CSR_TRAP_VALUE;
      csr_wdata = ~va;
      @(negedge clock);
      trap_valid = 1'b0;
      csr_valid = 1'b0;
      csr_write = 1'b0;
      trap_vaddr = ~trap_vaddr;
      trap_instr_bits = ~trap_instr_bits;
   endtask

endmodule

`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// Register and trap-entry tests for the trap value and environment block.
module tb_top
   import trap_env_pkg::*;
;

   // Pointer with low bits set; the device must clear the low three.
   localparam logic [63:0] PTR = 64'h0000_0000_8000_0007;
   // Instruction bits, a fault address base and a load page address.
   localparam logic [31:0] INSN = 32'h1234_ABCD;
   localparam logic [63:0] FA   = 64'hC000_0000_0000_0003;
   localparam logic [63:0] LPA  = 64'h0000_1234_5678_9ABC;

   logic        clock;        // Hart clock.
   logic        rst_n;        // Synchronous reset, active low.
   logic        priv_below_m; // Current mode is below machine.
   logic [4:0]  fin;          // Fence and atomic request bits.
   wire  [4:0]  fout;         // Ordering widened to memory.
   wire  [7:0]  lvl;          // Configuration levels, packed.
   wire  [63:0] trap_value;   // Trap value register contents.
   wire         v, w, rv, er, tv, ti, tiv;
   wire  [11:0] a;
   wire  [63:0] wd, rd, va;
   wire  [5:0]  tc;
   wire  [31:0] tb;
   wire  [3:0]  tp;
   int          miscompares;  // Mismatches seen.
   int          cmp_count;    // Comparisons made.
   int          cycles;       // Cycles since time zero.

   core_model i_core (.clock(clock), .csr_valid(v), .csr_write(w),
      .csr_addr(a), .csr_wdata(wd), .csr_rdata(rd), .csr_rvalid(rv),
      .csr_error(er), .trap_valid(tv), .trap_interrupt(ti),
      .trap_cause(tc), .trap_vaddr(va), .trap_instr_bits(tb),
      .trap_instr_parcels(tp), .trap_instr_valid(tiv));

   trap_env_csr #(.CONFIG_PTR(PTR)) i_dut (.clock(clock), .rst_n(rst_n),
      .csr_valid(v), .csr_write(w), .csr_addr(a), .csr_wdata(wd),
      .csr_rdata(rd), .csr_rvalid(rv), .csr_error(er), .trap_valid(tv),
      .trap_interrupt(ti), .trap_cause(tc), .trap_vaddr(va),
      .trap_instr_bits(tb), .trap_instr_parcels(tp),
      .trap_instr_valid(tiv), .priv_below_m(priv_below_m),
      .pred_dev_input(fin[0]), .pred_dev_output(fin[1]),
      .succ_dev_input(fin[2]), .succ_dev_output(fin[3]),
      .amo_io_ordered(fin[4]), .fence_pred_mem_read(fout[0]),
      .fence_pred_mem_write(fout[1]), .fence_succ_mem_read(fout[2]),
      .fence_succ_mem_write(fout[3]), .amo_order_memory(fout[4]),
      .fence_io_implies_memory(lvl[7]), .page_memtype_enable(lvl[6]),
      .hyp_memtype_allowed(lvl[5]), .supervisor_timecmp_enable(lvl[4]),
      .cache_block_zero_enable(lvl[3]),
      .cache_block_clean_flush_enable(lvl[2]),
      .cache_block_inval_enable(lvl[1:0]), .trap_value(trap_value));

   // Free-running clock at 25 MHz.
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Counts and reports one comparison.
   task automatic check(input string what, input logic [63:0] exp,
      input logic [63:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Access with expected error flag; read data is checked on reads only.
   task automatic acc(input logic wr, input logic [11:0] adr,
      input logic [63:0] wdat, input logic [63:0] exp, input logic eerr);
      logic [63:0] got;
      logic        ok;
      logic        err;
      i_core.access(wr, adr, wdat, got, ok, err);
      check($sformatf("rvalid %h", adr), 64'h1, {63'h0, ok});
      check($sformatf("error %h", adr), {63'h0, eerr}, {63'h0, err});
      if (!wr)
         check($sformatf("reg %h", adr), exp, got);
   endtask

   // Trap entry followed by a look at the register contents.
   task automatic trp(input logic intr, input logic [5:0] cause,
      input logic [63:0] vad, input logic [31:0] bits, input logic [3:0] np,
      input logic iv, input logic sw, input logic [63:0] exp);
      i_core.trap(intr, cause, vad, bits, np, iv, sw);
      check($sformatf("trap_value cause %h", cause), exp, trap_value);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // The tests take about a hundred cycles; a hang is cut at 3000.
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end

   // Address-type exception codes, each reporting the faulting address.
   logic [5:0] addr_causes [10] = '{EXC_INSTR_MISALIGN, EXC_INSTR_ACCESS,
      EXC_BREAKPOINT, EXC_LOAD_MISALIGN, EXC_LOAD_ACCESS, EXC_STORE_MISALIGN,
      EXC_STORE_ACCESS, EXC_INSTR_PAGE, EXC_LOAD_PAGE, EXC_STORE_PAGE};

   // Main sequence.
   initial
   begin
      rst_n = 1'b0;
      priv_below_m = 1'b0;
      fin = 5'h00;
      repeat (20) @(negedge clock);
      rst_n = 1'b1;
      acc(0, CSR_ENV_CONFIG, 64'h0, 64'h0, 0);
      acc(0, CSR_TRAP_VALUE, 64'h0, 64'h0, 0);
      acc(0, CSR_CONFIG_PTR, 64'h0, PTR & ~64'h7, 0);
      acc(1, CSR_CONFIG_PTR, '1, 64'h0, 1);
      acc(0, CSR_CONFIG_PTR, 64'h0, PTR & ~64'h7, 0);
      acc(0, 12'h123, 64'h0, 64'h0, 1);
      acc(0, CSR_ENV_CONFIG_HIGH, 64'h0, 64'h0, 1);
      acc(0, CSR_SEC_CONFIG_HIGH, 64'h0, 64'h0, 1);
      acc(0, CSR_SEC_CONFIG, 64'h0, 64'h0, 0);
      $display("test registers done");
      // Only the implemented enables may stick; reserved bits stay zero.
      acc(1, CSR_ENV_CONFIG, '1, 64'h0, 0);
      acc(0, CSR_ENV_CONFIG, 64'h0, 64'h4000_0000_0000_0001, 0);
      check("levels", 64'hE0, {56'h0, lvl});
      // Each fence bit alone, then all bits from machine mode.
      for (int i = 0; i < 6; i++)
      begin
         @(negedge clock);
         priv_below_m = (i < 5);
         fin = (i < 5) ? 5'h01 << i : 5'h1F;
         @(posedge clock);
         check("fence", (i < 5) ? {59'h0, fin} : 64'h0,
            {59'h0, fout});
      end
      // Inputs only ever change at the falling edge.
      @(negedge clock);
      priv_below_m = 1'b1;
      acc(1, CSR_ENV_CONFIG, 64'h0, 64'h0, 0);
      check("levels", 64'h0, {56'h0, lvl});
      check("fence", 64'h0, {59'h0, fout});
      $display("test environment done");
      // Address traps, with FA plus the index standing for the faulting part.
      for (int i = 0; i < 10; i++)
         trp(0, addr_causes[i], FA + 64'(i), 32'h0, 4'h2, 1, 0,
            FA + 64'(i));
      trp(0, EXC_ILLEGAL, 64'h0, INSN, 4'h1, 1, 0, 64'hABCD);
      trp(0, 6'h08, 64'h77, 32'h0, 4'h2, 1, 0, 64'h0);
      trp(0, EXC_ILLEGAL, 64'h0, INSN, 4'h2, 1, 0, 64'h1234_ABCD);
      trp(1, EXC_LOAD_ACCESS, 64'h55, 32'h0, 4'h2, 1, 0, 64'h0);
      trp(0, EXC_ILLEGAL, 64'h0, 32'hFFFF_FFFF, 4'h4, 1, 0,
         64'hFFFF_FFFF);
      trp(0, EXC_ILLEGAL, 64'h0, INSN, 4'h2, 0, 0, 64'h0);
      $display("test traps done");
      // Software writes, and a trap colliding with one.
      acc(1, CSR_TRAP_VALUE, 64'hFFFF_FFFF_FFFF_F000, 64'h0, 0);
      acc(0, CSR_TRAP_VALUE, 64'h0, 64'hFFFF_FFFF_FFFF_F000, 0);
      acc(1, CSR_TRAP_VALUE, 64'h0000_0000_FFFF_FFFF, 64'h0, 0);
      acc(0, CSR_TRAP_VALUE, 64'h0, 64'h0000_0000_FFFF_FFFF, 0);
      trp(0, EXC_LOAD_PAGE, LPA, 32'h0, 4'h2, 1, 1, LPA);
      repeat (5) @(negedge clock);
      acc(0, CSR_TRAP_VALUE, 64'h0, LPA, 0);
      $display("test software writes done");
      tally_and_finish();
   end

endmodule

`default_nettype wire
